// file: rtl/gei_edge_logic.sv
// Edge-triggered interrupt flags and programmable truth-table logic for a 16 IO expander.
// Assumes the pins are asynchronous to sys_clk and that the host settings are on sys_clk.
// Functional notes
// - Reset clears edge logic, releases interrupt line.
// - Interrupt mask resets to all ones.
// - Cause and event flags reset cleared.
// - Enabled rising/falling edges assert the interrupt.
// - Cause flags record which IOs interrupted.
// - Writing ones clears cause and event flags.
// - Mask zero enables, mask one blocks.
// - Two-bit edge code per IO, pairs.
// - Interrupt releases only when all causes clear.
// - Unassigned IOs keep general purpose behaviour.
// - Logic IOs get forced direction.
// - Logic IOs stay readable and interrupt capable.
// - Low mode field selects low functions.
// - High mode field configures IO4 to IO7.
// - Low code three gives three-to-two function.
// - Each eight-IO bank has own mode.
// - Programmable truth tables, four functions maximum.
// - Low two-input output indexes table zero bits, high one table two.
`timescale 1ns/100ps
module gei_edge_logic
  import gei_pkg::*;
(
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // IO pins, three signals each.
  input  wire logic [15:0] io_pin_in,
  output logic      [15:0] io_pin_out,
  output logic      [15:0] io_pin_oe,
  // General purpose settings.
  input  wire logic [15:0] io_value,
  input  wire logic [15:0] io_direction,
  output logic      [15:0] io_value_seen,
  input  wire logic        io_value_read,
  input  wire logic        extra_settings,
  // Interrupt settings and flags.
  input  wire logic        mask_load,
  input  wire logic [15:0] mask_data,
  output logic      [15:0] irq_enable_mask,
  input  wire logic [15:0] edge_select_lo,
  input  wire logic [15:0] edge_select_hi,
  input  wire logic        cause_clear,
  input  wire logic [15:0] cause_clear_data,
  output logic      [15:0] irq_cause_flags,
  output logic      [15:0] edge_event_flags,
  output logic             irq_out_low,
  output logic             irq_out_low_oe,
  // Truth-table logic settings.
  input  wire logic [7:0]  logic_mode_bank_lo,
  input  wire logic [7:0]  logic_mode_bank_hi,
  input  wire logic [31:0] truth_table_lo,
  input  wire logic [31:0] truth_table_hi
);

  logic [15:0] sync1_reg, sync2_reg, sync3_reg;  // Three-stage pin synchroniser.
  logic [15:0] prev_reg;                         // Last accepted pin level.
  logic        primed_reg;                       // High once prev_reg holds real levels.
  logic [1:0]  fill_reg;                         // Counts edges until all sync stages hold pin levels.
  logic [15:0] mask_reg, cause_reg, event_reg;   // Mask and sticky flags.
  logic        irq_reg;                          // Drives the interrupt line low.
  logic [15:0] out_reg, oe_reg, seen_reg;        // Pin drive and read-back flops.
  logic [31:0] sense_all;                        // Edge codes, IO0 in bits 1:0.
  logic [15:0] edge_hit;                         // Enabled, unmasked edges this cycle.
  logic [15:0] clr_bits;                         // Flags to clear this cycle.
  logic [15:0] cause_next, event_next;           // Next flag values.
  logic [15:0] pld_out, pld_in, pld_val;         // Logic function assignment and values.
  logic [15:0] oe_next, out_next;                // Next pin drive.
  logic [7:0]  mode_b [2];                       // Mode per bank.
  logic [31:0] table_b [2];                      // Tables per bank.

  assign sense_all = {edge_select_hi, edge_select_lo};
  assign mode_b[0] = logic_mode_bank_lo;
  assign mode_b[1] = logic_mode_bank_hi;
  assign table_b[0] = truth_table_lo;
  assign table_b[1] = truth_table_hi;

  // Per IO edge decode; a change counts once stages two and three agree.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IO; gi++) begin : g_edge
      logic stable, rise, fall;
      assign stable = primed_reg && (sync2_reg[gi] == sync3_reg[gi]);
      assign rise = stable && sync3_reg[gi] && !prev_reg[gi];
      assign fall = stable && !sync3_reg[gi] && prev_reg[gi];
      assign edge_hit[gi] = !mask_reg[gi] &&
                            ((rise && sense_all[2*gi +: 2] inside {SENSE_RISE, 2'h3}) ||
                             (fall && sense_all[2*gi +: 2] inside {SENSE_FALL, 2'h3}));
    end
  endgenerate

  // Per bank truth-table logic; tables zero and one serve the low nibble, two the high.
  generate
    for (gi = 0; gi < 2; gi++) begin : g_bank
      logic [1:0] lo, hi;
      logic [7:0] b, t0, t1, t2, po, pi, pv;
      assign lo = mode_b[gi][MODE_LO_POS +: 2];
      assign hi = mode_b[gi][MODE_HI_POS +: 2];
      assign b  = sync3_reg[BANK_IO*gi +: BANK_IO];
      assign t0 = table_b[gi][7:0];
      assign t1 = table_b[gi][15:8];
      assign t2 = table_b[gi][23:16];
      // Outputs marked, inputs marked, and output values; the high field is void under code three.
      assign po = {(lo != MODE_DUAL && hi == MODE_THREE), (lo != MODE_DUAL && hi == MODE_TWO), 1'b0,
                   (lo == MODE_DUAL), (lo inside {MODE_THREE, MODE_DUAL}), (lo == MODE_TWO), 2'h0};
      assign pi = {1'b0, (lo != MODE_DUAL && hi == MODE_THREE),
                   {2{lo != MODE_DUAL && hi != MODE_GPIO && hi != MODE_DUAL}}, 1'b0,
                   (lo inside {MODE_THREE, MODE_DUAL}), {2{lo != MODE_GPIO}}};
      assign pv = {t2[b[6:4]], t2[b[5:4]], 1'b0, t1[b[2:0]],
                   t0[b[2:0]], t0[b[1:0]], 2'h0};
      assign pld_out[BANK_IO*gi +: BANK_IO] = po;
      assign pld_in[BANK_IO*gi +: BANK_IO]  = pi;
      assign pld_val[BANK_IO*gi +: BANK_IO] = pv;
    end
  endgenerate

  // Direction forced for logic IOs; other IOs follow the direction setting (one means input).
  assign oe_next  = pld_out | (~pld_in & ~io_direction);
  assign out_next = (pld_out & pld_val) | (~pld_out & io_value);

  // Clears: host write of ones, or a data read when auto clear is enabled.
  assign clr_bits   = (cause_clear ? cause_clear_data : 16'h0000) |
                      ((io_value_read && extra_settings) ? 16'hffff : 16'h0000);
  assign cause_next = (cause_reg & ~clr_bits) | edge_hit;
  assign event_next = (event_reg & ~clr_bits) | edge_hit;

  // Pin synchroniser and previous-level tracking.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg  <= FLAGS_RST;
      sync2_reg  <= FLAGS_RST;
      sync3_reg  <= FLAGS_RST;
      prev_reg   <= FLAGS_RST;
      primed_reg <= 1'b0;
      fill_reg   <= 2'h0;
    end else begin
      sync1_reg  <= io_pin_in;
      sync2_reg  <= sync1_reg;
      sync3_reg  <= sync2_reg;
      // Priming waits until the third stage holds a sampled pin, so a pin high at reset is no edge.
      if (!(&fill_reg)) begin
        fill_reg <= fill_reg + 2'h1;
      end
      primed_reg <= &fill_reg;
      // Before priming the first levels load without counting as edges.
      for (int i = 0; i < NUM_IO; i++) begin
        if (!primed_reg || sync2_reg[i] == sync3_reg[i]) begin
          prev_reg[i] <= sync3_reg[i];
        end
      end
    end
  end

  // Mask, sticky flags and the interrupt line; a set in the clearing cycle wins.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_reg  <= MASK_RST;
      cause_reg <= FLAGS_RST;
      event_reg <= FLAGS_RST;
      irq_reg   <= 1'b0;
    end else begin
      if (mask_load) begin
        mask_reg <= mask_data;
      end
      cause_reg <= cause_next;
      event_reg <= event_next;
      irq_reg   <= |cause_reg;
    end
  end

  // Registered pin drive and read-back; logic IOs stay readable as inputs.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_reg  <= FLAGS_RST;
      oe_reg   <= FLAGS_RST;
      seen_reg <= FLAGS_RST;
    end else begin
      out_reg  <= out_next;
      oe_reg   <= oe_next;
      seen_reg <= sync3_reg;
    end
  end

  assign io_pin_out       = out_reg;
  assign io_pin_oe        = oe_reg;
  assign io_value_seen    = seen_reg;
  assign irq_enable_mask  = mask_reg;
  assign irq_cause_flags  = cause_reg;
  assign edge_event_flags = event_reg;
  assign irq_out_low      = 1'b0;
  assign irq_out_low_oe   = irq_reg;

  // Checks of the flag, interrupt and logic behaviour.
  property p_irq_follow;
    @(posedge sys_clk) disable iff (!rst_n) ##1 irq_reg == $past(|cause_reg);
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("interrupt line not tracking causes");

  property p_clear_all;
    @(posedge sys_clk) disable iff (!rst_n)
      (cause_clear && cause_clear_data == 16'hffff && edge_hit == 16'h0000) |=> cause_reg == 16'h0000;
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("clear of ones left a cause");

  property p_release_after_clear;
    @(posedge sys_clk) disable iff (!rst_n)
      (cause_clear && cause_clear_data == 16'hffff && edge_hit == 16'h0000) |=> ##1 !irq_reg;
  endproperty
  a_release_after_clear: assert property (p_release_after_clear) else $error("line not released");

  property p_set_recorded;
    @(posedge sys_clk) disable iff (!rst_n)
      (edge_hit != 16'h0000) |=> ((cause_reg & $past(edge_hit)) == $past(edge_hit)) ##1 irq_reg;
  endproperty
  a_set_recorded: assert property (p_set_recorded) else $error("edge not recorded");

  property p_masked_quiet;
    @(posedge sys_clk) disable iff (!rst_n) (cause_reg & ~$past(cause_reg) & $past(mask_reg)) == 16'h0000;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("masked IO raised a flag");

  property p_cause_has_event;
    @(posedge sys_clk) disable iff (!rst_n) (cause_reg & ~event_reg) == 16'h0000;
  endproperty
  a_cause_has_event: assert property (p_cause_has_event) else $error("cause without event");

  property p_auto_clear;
    @(posedge sys_clk) disable iff (!rst_n)
      (io_value_read && extra_settings && edge_hit == 16'h0000) |=> event_reg == 16'h0000;
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("read did not clear");

  property p_two_input_dir;
    @(posedge sys_clk) disable iff (!rst_n)
      (logic_mode_bank_lo == 8'h01) |=> (io_pin_oe[2:0] == 3'h4);
  endproperty
  a_two_input_dir: assert property (p_two_input_dir) else $error("direction not forced");

  property p_two_input_value;
    @(posedge sys_clk) disable iff (!rst_n)
      (logic_mode_bank_lo == 8'h01) |=> io_pin_out[2] == $past(truth_table_lo[{sync3_reg[1], sync3_reg[0]}]);
  endproperty
  a_two_input_value: assert property (p_two_input_value) else $error("table output wrong");

  property p_gpio_dir;
    @(posedge sys_clk) disable iff (!rst_n)
      (logic_mode_bank_lo == 8'h00) |=> io_pin_oe[7:0] == ~$past(io_direction[7:0]);
  endproperty
  a_gpio_dir: assert property (p_gpio_dir) else $error("general purpose direction lost");

  c_edge_irq: cover property (@(posedge sys_clk) disable iff (!rst_n) (edge_hit != 16'h0000) ##2 irq_reg);
  c_clear_irq: cover property (@(posedge sys_clk) disable iff (!rst_n) irq_reg && cause_clear ##2 !irq_reg);
  c_dual_mode: cover property (@(posedge sys_clk) disable iff (!rst_n) logic_mode_bank_hi[1:0] == MODE_DUAL);

endmodule : gei_edge_logic

// file: rtl/gei_pkg.sv
// Package for the edge interrupt and truth-table logic block of the IO expander.
// Assumes a single 200 MHz clock domain and no register bus; settings arrive as plain ports.
package gei_pkg;
  localparam int          NUM_IO      = 16;        // IO count of the widest variant.
  localparam int          BANK_IO     = 8;         // IOs served by one mode setting.
  localparam logic [15:0] MASK_RST    = 16'hffff;  // Interrupt mask after reset.
  localparam logic [15:0] FLAGS_RST   = 16'h0000;  // Cause and event flags after reset.
  localparam logic [1:0]  SENSE_RISE  = 2'h1;      // Edge code for rising edges.
  localparam logic [1:0]  SENSE_FALL  = 2'h2;      // Edge code for falling edges.
  localparam logic [1:0]  MODE_GPIO   = 2'h0;      // Mode field: all general purpose.
  localparam logic [1:0]  MODE_TWO    = 2'h1;      // Mode field: two inputs, one output.
  localparam logic [1:0]  MODE_THREE  = 2'h2;      // Mode field: three inputs, one output.
  localparam logic [1:0]  MODE_DUAL   = 2'h3;      // Low field: three inputs, two outputs.
  localparam int          MODE_LO_POS = 0;         // Position of the low-nibble mode field.
  localparam int          MODE_HI_POS = 4;         // Position of the high-nibble mode field.
endpackage : gei_pkg

// file: test/gei_pin_env.sv
// Model of the parts wired to the expander pins: outside drivers and the interrupt pull-up.
// Assumes the bench gives the level that outside parts put on every IO the device leaves undriven.
`timescale 1ns/100ps
module gei_pin_env (
  // Device side of each IO and of the interrupt line.
  input  wire logic [15:0] io_pin_out,
  input  wire logic [15:0] io_pin_oe,
  input  wire logic        irq_out_low,
  input  wire logic        irq_out_low_oe,
  // Bench side.
  input  wire logic [15:0] ext_level,
  output logic      [15:0] io_wire,
  output logic             irq_line
);
  // A driven IO shows the device value; any other shows the outside level.
  assign io_wire  = (io_pin_oe & io_pin_out) | (~io_pin_oe & ext_level);
  // The interrupt line has a pull-up, so it sits high unless the device pulls it.
  assign irq_line = irq_out_low_oe ? irq_out_low : 1'b1;
endmodule : gei_pin_env

// file: test/testbench.sv
// Self-checking bench for the edge interrupt and truth-table block.
// Assumes the pin model above resolves the IO wires and the interrupt line.
`timescale 1ns/100ps
module testbench;
  import gei_pkg::*;
  logic        sys_clk, rst_n, io_value_read, extra_settings, mask_load, cause_clear, irq_out_low, irq_oe, irq_line;
  logic [15:0] io_pin_in, io_pin_out, io_pin_oe, io_value, io_direction, io_value_seen, mask_data, irq_enable_mask;
  logic [15:0] edge_select_lo, edge_select_hi, cause_clear_data, irq_cause_flags, edge_event_flags, ext_level, e;
  logic [7:0]  logic_mode_bank_lo, logic_mode_bank_hi;
  logic [31:0] truth_table_lo, truth_table_hi;
  int          seed = 78902;
  int          err_count = 0;
  int          check_count = 0;
  // Device under test and the pin environment.
  gei_edge_logic dut (.sys_clk(sys_clk), .rst_n(rst_n), .io_pin_in(io_pin_in), .io_pin_out(io_pin_out),
    .io_pin_oe(io_pin_oe), .io_value(io_value), .io_direction(io_direction), .io_value_seen(io_value_seen),
    .io_value_read(io_value_read), .extra_settings(extra_settings), .mask_load(mask_load), .mask_data(mask_data),
    .irq_enable_mask(irq_enable_mask), .edge_select_lo(edge_select_lo), .edge_select_hi(edge_select_hi),
    .cause_clear(cause_clear), .cause_clear_data(cause_clear_data), .irq_cause_flags(irq_cause_flags),
    .edge_event_flags(edge_event_flags), .irq_out_low(irq_out_low), .irq_out_low_oe(irq_oe),
    .logic_mode_bank_lo(logic_mode_bank_lo), .logic_mode_bank_hi(logic_mode_bank_hi),
    .truth_table_lo(truth_table_lo), .truth_table_hi(truth_table_hi));
  gei_pin_env env (.io_pin_out(io_pin_out), .io_pin_oe(io_pin_oe), .irq_out_low(irq_out_low),
    .irq_out_low_oe(irq_oe), .ext_level(ext_level), .io_wire(io_pin_in), .irq_line(irq_line));
  // Free-running 200 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Waits a number of falling edges, where all inputs change.
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick
  // One-cycle host write to the cause flags, then time for flags and line to settle.
  task automatic clr(input logic [15:0] d);
    cause_clear      = 1'b1;
    cause_clear_data = d;
    tick(1);
    cause_clear = 1'b0;
    tick(3);
  endtask : clr
  // One-cycle load of a new interrupt mask.
  task automatic set_mask(input logic [15:0] d);
    mask_load = 1'b1;
    mask_data = d;
    tick(1);
    mask_load = 1'b0;
  endtask : set_mask
  // Expected drive for one function of a nibble: code 01 two inputs, code 10 three inputs.
  function automatic void place(input logic [1:0] f, input int b, input logic [7:0] tt, input logic [7:0] p,
                                inout logic [7:0] oe, inout logic [7:0] o);
    int         n;
    logic [2:0] ix;
    n  = (f == MODE_TWO) ? 2 : 3;
    ix = (f == MODE_TWO) ? {1'b0, p[b+1], p[b]} : {p[b+2], p[b+1], p[b]};
    if (f == MODE_TWO || f == MODE_THREE) begin
      for (int j = 0; j < n; j++) oe[b+j] = 1'b0;
      oe[b+n] = 1'b1;
      o[b+n]  = tt[ix];
    end
  endfunction : place
  // Expected {enable, driven value} of one eight-IO bank.
  function automatic logic [15:0] bank_exp(input logic [7:0] md, input logic [31:0] t, input logic [7:0] p,
                                           input logic [7:0] d, input logic [7:0] v);
    logic [7:0] oe, o;
    oe = ~d;
    o  = v;
    if (md[1:0] == MODE_DUAL) begin
      oe[4:0] = 5'h18;
      o[3]    = t[p[2:0]];
      o[4]    = t[8 + p[2:0]];
    end else begin
      place(md[1:0], 0, t[7:0], p, oe, o);
      place(md[5:4], 4, t[23:16], p, oe, o);
    end
    return {oe, o & oe};
  endfunction : bank_exp
  // Prints the verdict and ends the run.
  task automatic complete_run;
    if (err_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  // Cuts a hang short.
  initial begin
    #50000;
    err_count++;
    complete_run();
  end
  // Main sequence.
  initial begin
    {rst_n, io_value_read, extra_settings, mask_load, cause_clear} = '0;
    {mask_data, edge_select_lo, edge_select_hi, cause_clear_data, ext_level, io_value} = '0;
    {logic_mode_bank_lo, logic_mode_bank_hi, truth_table_lo, truth_table_hi} = '0;
    io_direction = 16'hffff;
    tick(16);
    check(irq_enable_mask, MASK_RST);
    check(irq_cause_flags | edge_event_flags, FLAGS_RST);
    check({14'h0, irq_oe, irq_line}, 16'h0001);
    rst_n = 1'b1;
    // Every edge code on IO1; IO2 senses both edges but stays masked.
    set_mask(16'hfffd);
    tick(1);
    check(irq_enable_mask, 16'hfffd);
    for (int c = 0; c < 4; c++) begin
      edge_select_lo = {10'h0, 2'h3, c[1:0], 2'h0};
      for (int ph = 0; ph < 2; ph++) begin
        clr(16'hffff);
        ext_level = ph ? 16'h0000 : 16'h0006;
        tick(8);
        e = c[ph] ? 16'h0002 : 16'h0000;
        check(irq_cause_flags, e);
        check(edge_event_flags, e);
        check({15'h0, irq_line}, {15'h0, ~e[1]});
      end
    end
    // Two causes cleared one at a time, then read-triggered clearing.
    set_mask(16'hfff5);
    edge_select_lo = 16'h00cc;
    clr(16'hffff);
    ext_level = 16'h000a;
    tick(8);
    check(irq_cause_flags, 16'h000a);
    clr(16'h0002);
    check(irq_cause_flags | edge_event_flags, 16'h0008);
    check({15'h0, irq_line}, 16'h0000);
    clr(16'h0008);
    check({15'h0, irq_line}, 16'h0001);
    ext_level = 16'h0000;
    tick(8);
    for (int es = 0; es < 2; es++) begin
      extra_settings = es[0];
      io_value_read  = 1'b1;
      tick(1);
      io_value_read = 1'b0;
      tick(3);
      check(irq_cause_flags, es ? 16'h0000 : 16'h000a);
    end
    // IO9 in the high edge codes senses falling edges only.
    set_mask(16'hfdff);
    edge_select_hi = 16'h0008;
    ext_level      = 16'h0200;
    tick(8);
    check(irq_cause_flags, 16'h0000);
    clr(16'hffff);
    ext_level = 16'h0000;
    tick(8);
    check(irq_cause_flags, 16'h0200);
    // Random tables, pins and directions over every mode code of the low bank, random modes in the high bank.
    for (int k = 0; k < 32; k++) begin
      logic_mode_bank_lo = {2'h0, 2'(k / 4), 2'h0, 2'(k)};
      logic_mode_bank_hi = {2'h0, 2'($random(seed)), 2'h0, 2'($random(seed))};
      truth_table_lo     = $random(seed);
      truth_table_hi     = $random(seed);
      ext_level          = 16'($random(seed));
      io_direction       = 16'($random(seed));
      io_value           = 16'($random(seed));
      // Logic outputs settle after five edges and reach the read-back four edges later.
      tick(12);
      check({io_pin_oe[7:0], io_pin_out[7:0] & io_pin_oe[7:0]}, bank_exp(logic_mode_bank_lo, truth_table_lo,
            ext_level[7:0], io_direction[7:0], io_value[7:0]));
      check({io_pin_oe[15:8], io_pin_out[15:8] & io_pin_oe[15:8]}, bank_exp(logic_mode_bank_hi, truth_table_hi,
            ext_level[15:8], io_direction[15:8], io_value[15:8]));
      check(io_value_seen, io_pin_in);
    end
    complete_run();
  end
endmodule : testbench
